// ==== hw/timer16_counter_capture.sv ====
// Counter unit and input capture unit of a 16-bit timer with an AXI4-Lite register slave.
// Assumes the timer tick sources and the comparator output are synchronous to aclk.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`default_nettype none
// Functional notes
// R01 - Clock select zero stops the counter
// R02 - Each tick clears, increments or decrements counter
// R03 - High byte location reaches the temporary register
// R04 - Low byte access moves high byte
// R05 - Counter accessible with or without timer clock
// R06 - CPU write beats clear or count
// R07 - Mode field split across control A, B
// R08 - Overflow flag set per mode, requests interrupt
// R09 - Bottom at zero, top at sequence maximum
// R10 - Qualified edge copies counter into capture
// R11 - Capture flag set with capture copy
// R12 - Capture flag interrupts, clears on service/write-one
// R13 - Capture low read loads temporary high
// R14 - Capture writable only in capture-top modes
// R15 - Comparator select switches trigger source
// R16 - Filter adds four cycles of delay
// R17 - Filter output changes when four samples agree
// R18 - Filter enabled by control B bit
// R19 - Capture input gated in capture-top modes
// R20 - New capture overwrites unread capture
// R21 - Port-driven pin level triggers capture too
// R22 - Software flips edge, then clears flag
// R23 - One temporary register for all 16-bit registers
// R24 - Software writes high first, reads low first
// R25 - Edge bit selects rising or falling
module timer16_counter_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tick_sources,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  output logic overflow_irq,
  output logic capture_irq,
  output logic bottom,
  output logic top,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import timer16_pkg::*;

  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [7:0] comparator_control_status;
  logic [15:0] counter_value;
  logic [15:0] capture_register;
  logic [7:0] temp_high;
  logic overflow_flag;
  logic capture_flag;
  logic overflow_irq_enable;
  logic capture_irq_enable;
  dir_t direction;
  axi_req_t wreq;
  logic aw_held;
  logic w_held;
  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  logic timer_tick;
  logic [15:0] top_value;
  logic capture_top_mode;
  logic [2:0] pwm_kind;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic [FILTER_LEN-1:0] filter_samples;
  logic filter_out;
  logic trig_prev;
  logic trig_level;
  logic edge_sel;
  logic capture_event;
  logic at_top;
  logic at_bottom;
  logic cnt_lo_write;
  logic cap_lo_write;
  logic [15:0] next_count;
  logic next_overflow;
  // Mode field lives in two halves of the control registers. [R07]
  assign clock_select_field = timer_control_b[CS_LSB +: 3];
  assign waveform_mode_field = {timer_control_b[WGM_B_LSB +: 2], timer_control_a[WGM_A_LSB +: 2]};
  assign edge_sel = timer_control_b[EDGE_BIT]; // [R25]
  // Tick source index 0 means no clock, so the counter stands still. [R01]
  assign timer_tick = (clock_select_field != 3'd0) && tick_sources[clock_select_field];
  // Top value per mode; capture-top modes are 8, 10, 12 and 14.
  always_comb
  begin
    capture_top_mode = 1'b0;
    case (waveform_mode_field)
      4'd1, 4'd5: top_value = TOP_8BIT;
      4'd2, 4'd6: top_value = TOP_9BIT;
      4'd3, 4'd7: top_value = TOP_10BIT;
      4'd8, 4'd10, 4'd12, 4'd14:
      begin
        top_value = capture_register;
        capture_top_mode = 1'b1;
      end
      default: top_value = CNT_MAX;
    endcase
    // Kind: 0 normal, 1 clear at top (fast/ctc), 2 up-down (phase correct).
    case (waveform_mode_field)
      4'd0: pwm_kind = 3'd0;
      4'd4, 4'd12, 4'd5, 4'd6, 4'd7, 4'd14, 4'd15: pwm_kind = 3'd1;
      default: pwm_kind = 3'd2;
    endcase
  end
  assign at_top = (counter_value == top_value); // [R09]
  assign at_bottom = (counter_value == CNT_ZERO); // [R09]
  // Next count and overflow event per mode. Compare-A top modes fall back to the
  // full range because the compare unit sits outside this block.
  always_comb
  begin
    case (pwm_kind)
      3'd1:
      begin
        next_count = at_top ? CNT_ZERO : 16'(counter_value + 16'h0001); // [R02]
        next_overflow = at_top; // [R08]
      end
      3'd2:
      begin
        if (direction == DIR_UP)
          next_count = at_top ? 16'(counter_value - 16'h0001)
                              : 16'(counter_value + 16'h0001); // [R02]
        else
          next_count = at_bottom ? 16'(counter_value + 16'h0001)
                                 : 16'(counter_value - 16'h0001); // [R02]
        next_overflow = at_bottom && (direction == DIR_DOWN); // [R08]
      end
      default:
      begin
        next_count = 16'(counter_value + 16'h0001); // [R02]
        next_overflow = (counter_value == CNT_MAX); // [R08]
      end
    endcase
  end
  // Trigger source choice; switching can itself look like an edge. [R15] [R21]
  assign trig_level = comparator_control_status[CMP_SEL_BIT] ? comparator_output : capture_pin;
  // Four-sample filter on the system clock, independent of the prescaler. [R17] [R18]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      filter_samples <= '0;
    else
      filter_samples <= {filter_samples[FILTER_LEN-2:0], trig_level}; // [R16]
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      filter_out <= 1'b0;
    else if (!timer_control_b[NF_BIT])
      filter_out <= trig_level; // [R18]
    else if (&filter_samples)
      filter_out <= 1'b1; // [R17]
    else if (~|filter_samples)
      filter_out <= 1'b0; // [R17]
  end
  // Edge detector, held quiet while the capture register defines top. [R19]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_prev <= 1'b0;
    else
      trig_prev <= filter_out;
  end
  assign capture_event = !capture_top_mode &&
                         (edge_sel ? (filter_out && !trig_prev)
                                   : (!filter_out && trig_prev)); // [R10] [R25] [R19]
  // AXI4-Lite write side: address and data taken in either order.
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = wr_fire && wreq.strb[0];
  assign cnt_lo_write = wr_hit && (wreq.addr == ADDR_CNT_LO);
  assign cap_lo_write = wr_hit && (wreq.addr == ADDR_CAP_LO) && capture_top_mode; // [R14]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wreq <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wreq.addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wreq.data <= s_axi_wdata;
        wreq.strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wreq.addr > ADDR_CMP_CTRL) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Control registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_a <= RESET_BYTE;
      timer_control_b <= RESET_BYTE;
      comparator_control_status <= RESET_BYTE;
      overflow_irq_enable <= 1'b0;
      capture_irq_enable <= 1'b0;
    end
    else if (wr_hit)
    begin
      case (wreq.addr)
        ADDR_CTRL_A: timer_control_a <= wreq.data[7:0];
        ADDR_CTRL_B: timer_control_b <= wreq.data[7:0];
        ADDR_CMP_CTRL: comparator_control_status <= wreq.data[7:0]; // [R15]
        ADDR_IRQ_EN:
        begin
          overflow_irq_enable <= wreq.data[OVF_BIT];
          capture_irq_enable <= wreq.data[CAP_BIT]; // [R12]
        end
        default: ;
      endcase
    end
  end

  // Counter: a CPU low-byte write wins over any tick in the same cycle. [R06] [R05]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter_value <= CNT_ZERO;
    else if (cnt_lo_write)
      counter_value <= {temp_high, wreq.data[7:0]}; // [R04] [R06]
    else if (timer_tick)
      counter_value <= next_count; // [R01] [R02]
  end

  // Direction for the up-down sequence turns at top and bottom.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      direction <= DIR_UP;
    else if (pwm_kind != 3'd2)
      direction <= DIR_UP;
    else if (timer_tick && !cnt_lo_write)
    begin
      if (at_top)
        direction <= DIR_DOWN;
      else if (at_bottom)
        direction <= DIR_UP;
    end
  end

  // Capture register: every event overwrites it, read or not. [R20]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_register <= CNT_ZERO;
    else if (capture_event)
      capture_register <= counter_value; // [R10] [R20]
    else if (cap_lo_write)
      capture_register <= {temp_high, wreq.data[7:0]}; // [R14]
  end

  // Flags: a hardware set in the same cycle beats a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
    end
    else
    begin
      if (timer_tick && !cnt_lo_write && next_overflow)
        overflow_flag <= 1'b1; // [R08]
      else if (ovf_irq_ack || (wr_hit && wreq.addr == ADDR_FLAGS && wreq.data[OVF_BIT]))
        overflow_flag <= 1'b0;
      if (capture_event)
        capture_flag <= 1'b1; // [R11]
      else if (cap_irq_ack || (wr_hit && wreq.addr == ADDR_FLAGS && wreq.data[CAP_BIT]))
        capture_flag <= 1'b0; // [R12] [R22]
    end
  end

  // Read decode for the byte locations.
  always_comb
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      ADDR_CTRL_A: rd_byte = timer_control_a;
      ADDR_CTRL_B: rd_byte = timer_control_b;
      ADDR_CNT_LO: rd_byte = counter_value[7:0];
      ADDR_CNT_HI: rd_byte = temp_high; // [R03]
      ADDR_CAP_LO: rd_byte = capture_register[7:0];
      ADDR_CAP_HI: rd_byte = temp_high; // [R13]
      ADDR_FLAGS: rd_byte = {2'b00, capture_flag, 4'b0000, overflow_flag};
      ADDR_IRQ_EN: rd_byte = {2'b00, capture_irq_enable, 4'b0000, overflow_irq_enable};
      ADDR_CMP_CTRL: rd_byte = comparator_control_status;
      default:
      begin
        rd_byte = RESET_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // AXI4-Lite read side: one read in flight, answer one cycle after address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // One temporary byte serves every 16-bit register. [R23]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      temp_high <= RESET_BYTE;
    else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == ADDR_CNT_LO)
      temp_high <= counter_value[15:8]; // [R04]
    else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == ADDR_CAP_LO)
      temp_high <= capture_register[15:8]; // [R13]
    else if (wr_hit && (wreq.addr == ADDR_CNT_HI || wreq.addr == ADDR_CAP_HI))
      temp_high <= wreq.data[7:0]; // [R03] [R24]
  end

  // Registered status outputs.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
      bottom <= 1'b0;
      top <= 1'b0;
    end
    else
    begin
      overflow_irq <= overflow_flag && overflow_irq_enable; // [R08]
      capture_irq <= capture_flag && capture_irq_enable; // [R12]
      bottom <= at_bottom; // [R09]
      top <= at_top; // [R09]
    end
  end
endmodule : timer16_counter_capture
`default_nettype wire

// ==== include/timer16_pkg.sv ====
// Package for the 16-bit counter and input capture block.
// Assumes an AXI4-Lite master with 32-bit data; each byte location is one aligned word.
`default_nettype none
package timer16_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_CAP_LO = 8'h10;
  localparam logic [7:0] ADDR_CAP_HI = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h20;
  // Field positions.
  localparam int CS_LSB = 0;
  localparam int WGM_B_LSB = 3;
  localparam int EDGE_BIT = 6;
  localparam int NF_BIT = 7;
  localparam int WGM_A_LSB = 0;
  localparam int OVF_BIT = 0;
  localparam int CAP_BIT = 5;
  localparam int CMP_SEL_BIT = 2;
  localparam int ACK_OVF_BIT = 0;
  localparam int ACK_CAP_BIT = 1;
  localparam int FILTER_LEN = 4;
  // Reset values and constants.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // One AXI4-Lite request as seen by the slave.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } axi_req_t;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage : timer16_pkg
`default_nettype wire

// ==== testbench/timer16_sva.sv ====
// Port-level assertions for the timer counter and capture block.
// Assumes it is bound into the design top and sees only its ports.
`default_nettype none
module timer16_sva
  import timer16_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  input wire logic overflow_irq,
  input wire logic capture_irq,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Answers must stand until taken, or a slow master loses them.
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read answer without address");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready
    && {s_axi_araddr[7:2], 2'b00} > ADDR_CMP_CTRL |=> s_axi_rvalid
    && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_cap_ack: assert property (cap_irq_ack |-> ##[1:2] !capture_irq)
    else $error("capture request not cleared by service");
  a_ovf_ack: assert property (ovf_irq_ack |-> ##[1:2] !overflow_irq)
    else $error("overflow request not cleared by service");
  // Reset itself is checked, so this one is never disabled.
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
    && !s_axi_rvalid && !capture_irq && !overflow_irq) else $error("busy after reset");
  cover property ($rose(capture_irq));
  cover property ($rose(overflow_irq));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : timer16_sva
bind timer16_counter_capture timer16_sva chk (
  .aclk(aclk), .aresetn(aresetn), .ovf_irq_ack(ovf_irq_ack),
  .cap_irq_ack(cap_irq_ack), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ==== testbench/cpu_model.sv ====
// Bus master standing in for the processor core, one byte per access.
// Assumes the slave answers; only the bench watchdog ends a hang.
`default_nettype none
module cpu_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero.
  initial
  begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wstrb = 4'h1;
    s_axi_wdata = 32'h0000_0000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
  end
  // Released lines show the inverse so stale values are never mistaken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
      end
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask : rd
endmodule : cpu_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the timer counter and capture block.
// Assumes the processor model and the bound checker are compiled with it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer16_pkg::*;
  logic aclk, aresetn, capture_pin, comparator_output, ovf_irq_ack, cap_irq_ack;
  logic [7:0] tick_sources, s_axi_awaddr, s_axi_araddr, v;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic overflow_irq, capture_irq, bottom, top;
  int n_fail = 0;
  int total_checks = 0;
  int n_off, n_on;
  timer16_counter_capture dut (.*);
  cpu_model cpu (.*);
  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.wr(a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cpu.rd(a, v, r);
    check({8'h00, v}, {8'h00, e});
  endtask : rd
  // High byte goes first so the low write moves both bytes at once.
  task automatic wr16(input logic [7:0] la, input logic [15:0] d);
    wr(la + 8'h04, d[15:8]);
    wr(la, d[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] la, input logic [15:0] e);
    rd(la, e[7:0]);
    rd(la + 8'h04, e[15:8]);
  endtask : rd16
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : wait_n
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge aclk) tick_sources <= 8'hFE;
      @(posedge aclk) tick_sources <= 8'h00;
    end
  endtask : tick
  task automatic pin(input logic p);
    @(posedge aclk) capture_pin <= p;
    wait_n(6);
  endtask : pin
  task automatic irq_is(input logic e);
    check({15'h0000, capture_irq}, {15'h0000, e});
  endtask : irq_is
  // Cycles from a rising pin to the capture request.
  task automatic lat(output int n);
    n = 0;
    @(posedge aclk) capture_pin <= 1'b1;
    #1;
    while (capture_irq !== 1'b1 && n < 40)
    begin
      wait_n(1);
      n++;
    end
  endtask : lat
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Watchdog: the tests need a few thousand cycles at most.
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end
  initial
  begin
    aresetn = 1'b0;
    tick_sources = 8'h00;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    ovf_irq_ack = 1'b0;
    cap_irq_ack = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL_B, 8'h00);
    wr16(ADDR_CNT_LO, 16'h1234);
    tick(4);
    rd16(ADDR_CNT_LO, 16'h1234);
    wr(ADDR_CAP_HI, 8'h9A);
    rd(ADDR_CNT_HI, 8'h9A);
    wr(ADDR_CNT_LO, 8'h78);
    wr(ADDR_CTRL_B, 8'h01);
    tick(3);
    rd16(ADDR_CNT_LO, 16'h9A7B);
    wr(ADDR_IRQ_EN, 8'h21);
    wr16(ADDR_CNT_LO, 16'hFFFF);
    tick(1);
    wait_n(3);
    check({15'h0000, overflow_irq}, 16'h0001);
    check({15'h0000, bottom}, 16'h0001);
    rd(ADDR_FLAGS, 8'h01);
    @(posedge aclk) ovf_irq_ack <= 1'b1;
    @(posedge aclk) ovf_irq_ack <= 1'b0;
    wait_n(2);
    check({15'h0000, overflow_irq}, 16'h0000);
    $display("test counter done");
    wr(ADDR_CTRL_B, 8'h40);
    wr16(ADDR_CNT_LO, 16'h0AB0);
    pin(1'b1);
    irq_is(1'b1);
    wr16(ADDR_CNT_LO, 16'h1234);
    pin(1'b0);
    pin(1'b1);
    rd16(ADDR_CAP_LO, 16'h1234);
    @(posedge aclk) cap_irq_ack <= 1'b1;
    @(posedge aclk) cap_irq_ack <= 1'b0;
    wait_n(2);
    irq_is(1'b0);
    pin(1'b0);
    irq_is(1'b0);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_FLAGS, 8'h20);
    wr16(ADDR_CNT_LO, 16'h0077);
    pin(1'b1);
    irq_is(1'b0);
    pin(1'b0);
    irq_is(1'b1);
    rd16(ADDR_CAP_LO, 16'h0077);
    wr(ADDR_FLAGS, 8'h20);
    wait_n(2);
    irq_is(1'b0);
    $display("test capture done");
    wr(ADDR_CTRL_B, 8'h40);
    lat(n_off);
    wr(ADDR_FLAGS, 8'h20);
    wr(ADDR_CTRL_B, 8'hC0);
    pin(1'b0);
    lat(n_on);
    check(16'(n_on - n_off), 16'h0004);
    wr(ADDR_FLAGS, 8'h20);
    pin(1'b0);
    @(posedge aclk) capture_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    capture_pin <= 1'b0;
    wait_n(10);
    irq_is(1'b0);
    $display("test filter done");
    wr(ADDR_CTRL_B, 8'h40);
    wr(ADDR_CMP_CTRL, 8'h04);
    wr(ADDR_FLAGS, 8'h20);
    wr16(ADDR_CNT_LO, 16'h0C0D);
    pin(1'b1);
    irq_is(1'b0);
    @(posedge aclk) comparator_output <= 1'b1;
    wait_n(6);
    irq_is(1'b1);
    rd16(ADDR_CAP_LO, 16'h0C0D);
    wr(ADDR_FLAGS, 8'h20);
    wr16(ADDR_CAP_LO, 16'h5555);
    rd16(ADDR_CAP_LO, 16'h0C0D);
    wr(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CTRL_B, 8'h58);
    wr16(ADDR_CAP_LO, 16'h0321);
    rd16(ADDR_CAP_LO, 16'h0321);
    @(posedge aclk) comparator_output <= 1'b0;
    wait_n(6);
    @(posedge aclk) comparator_output <= 1'b1;
    wait_n(6);
    irq_is(1'b0);
    wr16(ADDR_CNT_LO, 16'h0321);
    wait_n(3);
    check({15'h0000, top}, 16'h0001);
    wr(ADDR_CTRL_B, 8'h59);
    tick(1);
    wait_n(3);
    check({15'h0000, overflow_irq}, 16'h0001);
    rd16(ADDR_CNT_LO, 16'h0000);
    wr(ADDR_FLAGS, 8'h01);
    wr(ADDR_CTRL_A, 8'h01);
    wr(ADDR_CTRL_B, 8'h41);
    wr16(ADDR_CNT_LO, 16'h00FE);
    tick(3);
    rd16(ADDR_CNT_LO, 16'h00FD);
    check({15'h0000, overflow_irq}, 16'h0000);
    wr16(ADDR_CNT_LO, 16'h0001);
    tick(2);
    wait_n(3);
    check({15'h0000, overflow_irq}, 16'h0001);
    cpu.rd(8'h24, v, r);
    check({14'h0000, r}, {14'h0000, RESP_SLVERR});
    cpu.wr(8'h24, 8'h00, r);
    check({14'h0000, r}, {14'h0000, RESP_SLVERR});
    $display("test modes done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
